// ===== rtl/pcw_params.svh
`ifndef PCW_PARAMS_SVH
`define PCW_PARAMS_SVH
// register word indices, byte address = index * 4
`define PCW_IDX_ICR 8'h06
`define PCW_IDX_JUST_WIN 8'h11
`define PCW_IDX_HEC_WIN 8'h12
`define PCW_IDX_FULL_WIN 8'h13
`define PCW_IDX_IDLE_WIN 8'h14
`define PCW_IDX_VALID_WIN 8'h15
`define PCW_IDX_PTR1 8'h19
`define PCW_IDX_PTR2 8'h1A
`define PCW_IDX_SAMPLE 8'h1B
`define PCW_IDX_CLR1 8'h1C
`define PCW_IDX_CLR2 8'h1D
`define PCW_IDX_OVF1 8'h20
`define PCW_IDX_OVF2 8'h21
// field positions
`define PCW_BIT_JUST 0
`define PCW_BIT_VALID 0
`define PCW_BIT_IDLE 2
`define PCW_BIT_FULL 4
`define PCW_BIT_HEC 6
`define PCW_CLR_HEC 3
`define PCW_CLR_FULL 2
`define PCW_CLR_IDLE 1
`define PCW_CLR_VALID 0
`define PCW_BIT_PCO 0
`define PCW_BIT_SMP 0
// reset values
`define PCW_PTR_RESET 8'h00
`define PCW_CTRL_RESET 8'h00
`endif

// ===== rtl/pcw_pkg.sv
package pcw_pkg;
    // live counter set: index 0 is justification, 1..4 the cell counters
    typedef enum logic [2:0] {
        PCW_JUST,
        PCW_HEC,
        PCW_FULL,
        PCW_IDLE,
        PCW_VALID
    } pcw_ctr_t;
    typedef struct packed {
        logic [19:0] live;
        logic [19:0] load;
        logic ovf;
    } pcw_ctr_state_t;
endpackage : pcw_pkg

// ===== rtl/pcw_ctr_if.sv
`timescale 1ns/10ps
// control and results shared between the top and one counter slice
interface pcw_ctr_if;
    logic event_in;
    logic sample;
    logic clear;
    logic [19:0] load;
    logic ovf_pulse;
    modport ctr (input event_in, sample, clear, output load, ovf_pulse);
    modport top (output event_in, sample, clear, input load, ovf_pulse);
endinterface : pcw_ctr_if

// ===== rtl/pcw_counter.sv
`timescale 1ns/10ps
module pcw_counter
    import pcw_pkg::*;
#(
    parameter int WIDTH = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    pcw_ctr_if.ctr c
);
    typedef struct packed {
        logic [WIDTH-1:0] live;
        logic [WIDTH-1:0] load;
        logic ovf_pulse;
    } pcw_cnt_st_t;
    pcw_cnt_st_t st;
    pcw_cnt_st_t next_st;
    localparam logic [WIDTH-1:0] ALL_ONES = '1;

    // snapshot and clear in one edge so an event lands in one interval
    always_comb begin
        next_st = st;
        next_st.ovf_pulse = 1'b0;
        if (c.sample) begin
            next_st.load = st.live;
            next_st.live = {{(WIDTH-1){1'b0}}, c.event_in};
        end else if (c.clear) begin
            next_st.live = '0;
        end else if (c.event_in) begin
            next_st.live = st.live + 1'b1; // wraps, never sticks
            if (st.live + 1'b1 == ALL_ONES) begin
                next_st.ovf_pulse = 1'b1; // reached all ones
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign c.load = 20'(st.load);
    assign c.ovf_pulse = st.ovf_pulse;
endmodule : pcw_counter

// ===== rtl/pcw_top.sv
// Function
// - 12-bit justification value read as two bytes
// - justification pointer toggles per window read
// - sample copies live counters into load
// - load holds until next sample
// - sampling clears live counter
// - clear bit zeroes justification counter
// - justification overflow sets flag and irq
// - counters keep counting after overflow
// - header error value read in three bytes
// - two-bit pointer walks 00,01,10,00
// - count cells dropped on header error
// - clear bit zeroes header error counter
// - header error overflow sets flag, irq
// - count cells dropped on fifo full
// - fifo full clear and overflow flag
// - count idle cells, own window
// - idle clear and overflow flag
// - count cells passed to atm layer
// - valid cell pointer and clear bit
// - pointer register one layout and reset
// - third read gives bits 19..16
// - sample bit self-clears
// - clear bits self-clear, loads untouched
`timescale 1ns/10ps
`include "pcw_params.svh"
module pcw_top
    import pcw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic just_event,
    input wire logic hec_drop_event,
    input wire logic fifo_full_event,
    input wire logic idle_cell_event,
    input wire logic valid_cell_event,
    output logic irq
);
    localparam int NCTR = 5;

    // all top state in one struct
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [7:0] ptr1;
        logic [7:0] ptr2;
        logic sample;
        logic [3:0] clr2;
        logic clr_just;
        logic [7:0] ovf1;
        logic [7:0] ovf2;
        logic counter_overflow_irq;
        logic [4:0] ev_s1;
        logic [4:0] ev_s2;
    } pcw_top_st_t;
    pcw_top_st_t st;
    pcw_top_st_t next_st;

    logic [4:0] ev_raw;
    logic [4:0] ovf_hit;
    logic [19:0] load_val [NCTR];
    logic [4:0] clr_vec;

    assign ev_raw = {valid_cell_event, idle_cell_event, fifo_full_event,
                     hec_drop_event, just_event};
    assign clr_vec = {st.clr2[`PCW_CLR_VALID], st.clr2[`PCW_CLR_IDLE],
                      st.clr2[`PCW_CLR_FULL], st.clr2[`PCW_CLR_HEC],
                      st.clr_just};

    // one counter slice per statistic; event inputs come from pins
    // so they pass the two-flop synchroniser first
    pcw_ctr_if cif [NCTR] ();
    generate
        for (genvar g = 0; g < NCTR; g++) begin : g_ctr
            assign cif[g].event_in = st.ev_s2[g];
            assign cif[g].sample = st.sample;
            assign cif[g].clear = clr_vec[g];
            assign load_val[g] = cif[g].load;
            assign ovf_hit[g] = cif[g].ovf_pulse;
            pcw_counter #(.WIDTH(g == 0 ? 12 : 20)) u_ctr (
                .pclk(pclk),
                .presetn(presetn),
                .c(cif[g])
            );
        end
    endgenerate

    // byte of a 20-bit load chosen by a two-bit pointer
    function automatic logic [7:0] pick3(input logic [19:0] v,
                                         input logic [1:0] p);
        logic [7:0] r;
        r = 8'h00;
        unique case (p)
            2'b00: r = v[7:0];
            2'b01: r = v[15:8];
            2'b10: r = {4'h0, v[19:16]};
            default: r = 8'h00;
        endcase
        return r;
    endfunction : pick3

    // pointer step 00 -> 01 -> 10 -> 00; 11 written by software wraps
    function automatic logic [1:0] step3(input logic [1:0] p);
        return (p == 2'b10 || p == 2'b11) ? 2'b00 : p + 2'b01;
    endfunction : step3

    logic setup;
    logic [7:0] idx;
    assign setup = psel && !penable;
    assign idx = paddr[9:2];

    always_comb begin
        next_st = st;
        // first flop feeds only the second
        next_st.ev_s1 = ev_raw;
        next_st.ev_s2 = st.ev_s1;
        // command bits live one cycle then drop by themselves
        next_st.sample = 1'b0;
        next_st.clr2 = 4'h0;
        next_st.clr_just = 1'b0;
        next_st.pready = 1'b0;
        // sticky overflow causes; set wins over any clear
        if (ovf_hit[PCW_JUST]) next_st.ovf1[`PCW_BIT_JUST] = 1'b1;
        next_st.ovf2[`PCW_CLR_HEC] = st.ovf2[`PCW_CLR_HEC]
            | ovf_hit[PCW_HEC];
        next_st.ovf2[`PCW_CLR_FULL] = st.ovf2[`PCW_CLR_FULL]
            | ovf_hit[PCW_FULL];
        next_st.ovf2[`PCW_CLR_IDLE] = st.ovf2[`PCW_CLR_IDLE]
            | ovf_hit[PCW_IDLE];
        next_st.ovf2[`PCW_CLR_VALID] = st.ovf2[`PCW_CLR_VALID]
            | ovf_hit[PCW_VALID];
        if (|ovf_hit) begin
            next_st.counter_overflow_irq = 1'b1;
        end
        // apb: answer in the access cycle, one wait-free beat
        if (setup) begin
            next_st.pready = 1'b1;
            next_st.pslverr = 1'b0;
            next_st.prdata = 32'h0000_0000;
            if (pwrite) begin
                unique case (idx)
                    `PCW_IDX_PTR1: next_st.ptr1 = pwdata[7:0];
                    `PCW_IDX_PTR2: next_st.ptr2 = pwdata[7:0];
                    `PCW_IDX_SAMPLE:
                        next_st.sample = pwdata[`PCW_BIT_SMP];
                    `PCW_IDX_CLR1:
                        next_st.clr_just = pwdata[`PCW_BIT_JUST];
                    `PCW_IDX_CLR2:
                        next_st.clr2 = pwdata[3:0];
                    `PCW_IDX_JUST_WIN, `PCW_IDX_HEC_WIN, `PCW_IDX_FULL_WIN,
                    `PCW_IDX_IDLE_WIN, `PCW_IDX_VALID_WIN, `PCW_IDX_OVF1,
                    `PCW_IDX_OVF2, `PCW_IDX_ICR: ;
                    default: next_st.pslverr = 1'b1;
                endcase
            end else begin
                unique case (idx)
                    `PCW_IDX_JUST_WIN: begin
                        // low byte then low nibble of top
                        next_st.prdata[7:0] = st.ptr1[`PCW_BIT_JUST]
                            ? {4'h0, load_val[PCW_JUST][11:8]}
                            : load_val[PCW_JUST][7:0];
                        next_st.ptr1[`PCW_BIT_JUST] =
                            ~st.ptr1[`PCW_BIT_JUST];
                    end
                    `PCW_IDX_HEC_WIN: begin
                        next_st.prdata[7:0] = pick3(load_val[PCW_HEC],
                            st.ptr2[`PCW_BIT_HEC +: 2]);
                        next_st.ptr2[`PCW_BIT_HEC +: 2] =
                            step3(st.ptr2[`PCW_BIT_HEC +: 2]);
                    end
                    `PCW_IDX_FULL_WIN: begin
                        next_st.prdata[7:0] = pick3(load_val[PCW_FULL],
                            st.ptr2[`PCW_BIT_FULL +: 2]);
                        next_st.ptr2[`PCW_BIT_FULL +: 2] =
                            step3(st.ptr2[`PCW_BIT_FULL +: 2]);
                    end
                    `PCW_IDX_IDLE_WIN: begin
                        next_st.prdata[7:0] = pick3(load_val[PCW_IDLE],
                            st.ptr2[`PCW_BIT_IDLE +: 2]);
                        next_st.ptr2[`PCW_BIT_IDLE +: 2] =
                            step3(st.ptr2[`PCW_BIT_IDLE +: 2]);
                    end
                    `PCW_IDX_VALID_WIN: begin
                        next_st.prdata[7:0] = pick3(load_val[PCW_VALID],
                            st.ptr2[`PCW_BIT_VALID +: 2]);
                        next_st.ptr2[`PCW_BIT_VALID +: 2] =
                            step3(st.ptr2[`PCW_BIT_VALID +: 2]);
                    end
                    `PCW_IDX_PTR1: next_st.prdata[7:0] = st.ptr1;
                    `PCW_IDX_PTR2: next_st.prdata[7:0] = st.ptr2;
                    // command bits always read back zero once done
                    `PCW_IDX_SAMPLE, `PCW_IDX_CLR1, `PCW_IDX_CLR2: ;
                    `PCW_IDX_OVF1: begin
                        next_st.prdata[7:0] = st.ovf1;
                        next_st.ovf1 = 8'h00;
                        // a hit this same cycle survives the clear
                        if (ovf_hit[PCW_JUST]) begin
                            next_st.ovf1[`PCW_BIT_JUST] = 1'b1;
                        end
                    end
                    `PCW_IDX_OVF2: begin
                        next_st.prdata[7:0] = st.ovf2;
                        // read clears; a hit this cycle keeps its own bit
                        next_st.ovf2 = 8'h00;
                        next_st.ovf2[`PCW_CLR_HEC] = ovf_hit[PCW_HEC];
                        next_st.ovf2[`PCW_CLR_FULL] = ovf_hit[PCW_FULL];
                        next_st.ovf2[`PCW_CLR_IDLE] = ovf_hit[PCW_IDLE];
                        next_st.ovf2[`PCW_CLR_VALID] = ovf_hit[PCW_VALID];
                    end
                    `PCW_IDX_ICR: begin
                        next_st.prdata[`PCW_BIT_PCO] = st.counter_overflow_irq;
                        next_st.counter_overflow_irq = |ovf_hit; // read clears, set wins
                    end
                    default: next_st.pslverr = 1'b1;
                endcase
            end
        end
        next_st.irq = next_st.counter_overflow_irq;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0; // pointers and controls reset to 00H
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign irq = st.irq;
endmodule : pcw_top

// ===== test/pcw_top_chk.sv
`timescale 1ns/10ps
module pcw_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic just_event,
    input wire logic hec_drop_event,
    input wire logic fifo_full_event,
    input wire logic idle_cell_event,
    input wire logic valid_cell_event,
    input wire logic irq
);
    logic [7:0] idx;
    logic known;
    // word index and the set of mapped registers
    assign idx = paddr[9:2];
    assign known = idx inside {8'h06, [8'h11:8'h15], [8'h19:8'h1D],
        8'h20, 8'h21};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read;
        pready && psel && penable && !pwrite;
    endsequence
    // bus answers in the access cycle, one pulse per transfer
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_map: assert property (pready |-> pslverr == !known)
        else $error("pslverr wrong for index");
    a_upper_zero: assert property (s_read |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    // control bits must have cleared themselves by the time they are read
    a_sample_selfclr: assert property (s_read ##0 (idx == 8'h1B)
        |-> prdata[7:0] == 8'h00) else $error("sample bit stuck");
    a_clear_selfclr: assert property (s_read ##0
        (idx inside {8'h1C, 8'h1D}) |-> prdata[7:0] == 8'h00)
        else $error("clear bit stuck");
    a_irq_drop: assert property (s_read ##0
        (idx == 8'h06 && prdata[0]) |-> ##[1:3] !irq)
        else $error("irq not cleared by cause read");
endmodule : pcw_top_chk
bind pcw_top pcw_top_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .just_event(just_event),
    .hec_drop_event(hec_drop_event), .fifo_full_event(fifo_full_event),
    .idle_cell_event(idle_cell_event),
    .valid_cell_event(valid_cell_event), .irq(irq));

// ===== test/test_performance_counter_windows.sv
`timescale 1ns/10ps
module test_performance_counter_windows;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, er;
    logic [4:0] ev = 5'h00;
    int error_cnt = 0;
    int checks = 0;
    // 10 MHz bus clock
    always #50 pclk = ~pclk;
    pcw_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .just_event(ev[0]), .hec_drop_event(ev[1]),
        .fifo_full_event(ev[2]), .idle_cell_event(ev[3]),
        .valid_cell_event(ev[4]), .irq(irq));
    task results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one transfer; the wait is bounded so a dead slave ends the run
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, pready, 1'b1);
            results();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb
    task rd_chk(input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h000000, e});
    endtask : rd_chk
    task rd20(input logic [7:0] idx, input logic [19:0] v);
        rd_chk(idx, v[7:0]);
        rd_chk(idx, v[15:8]);
        rd_chk(idx, {4'h0, v[19:16]});
    endtask : rd20
    // every window in byte order; pointers end back at zero
    task loads(input logic [11:0] j, input logic [19:0] h, f, i, v);
        rd_chk(8'h11, j[7:0]);
        rd_chk(8'h11, {4'h0, j[11:8]});
        rd20(8'h12, h);
        rd20(8'h13, f);
        rd20(8'h14, i);
        rd20(8'h15, v);
    endtask : loads
    // pins held high for n cycles count n events; all low at the end
    task pulse(input int j, h, f, i, v);
        for (int k = 0; k < 4096; k++) begin
            @(posedge pclk);
            ev <= {k < v, k < i, k < f, k < h, k < j};
        end
        repeat (6) @(posedge pclk);
    endtask : pulse
    task sample_now;
        apb(1'b1, 8'h1B, 8'h01);
        repeat (2) @(posedge pclk);
    endtask : sample_now
    task t_reset;
        rd_chk(8'h19, 8'h00);
        rd_chk(8'h1A, 8'h00);
        rd_chk(8'h1B, 8'h00);
        rd_chk(8'h20, 8'h00);
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h06, 8'h00);
        chk({31'h00000000, irq}, 32'h00000000);
        $display("reset test done");
    endtask : t_reset
    task t_sample;
        pulse(2500, 3125, 935, 2079, 4080);
        sample_now();
        rd_chk(8'h1B, 8'h00);
        loads(12'h9C4, 20'h00C35, 20'h003A7, 20'h0081F, 20'h00FF0);
        pulse(3, 4, 5, 6, 7);
        loads(12'h9C4, 20'h00C35, 20'h003A7, 20'h0081F, 20'h00FF0);
        sample_now();
        loads(12'h003, 20'h00004, 20'h00005, 20'h00006, 20'h00007);
        $display("sample test done");
    endtask : t_sample
    task t_pointer;
        rd_chk(8'h12, 8'h04);
        rd_chk(8'h1A, 8'h40);
        rd_chk(8'h12, 8'h00);
        rd_chk(8'h1A, 8'h80);
        rd_chk(8'h12, 8'h00);
        rd_chk(8'h1A, 8'h00);
        apb(1'b1, 8'h19, 8'h01);
        rd_chk(8'h19, 8'h01);
        rd_chk(8'h11, 8'h00);
        rd_chk(8'h19, 8'h00);
        $display("pointer test done");
    endtask : t_pointer
    task t_clear;
        pulse(9, 9, 9, 9, 9);
        apb(1'b1, 8'h1C, 8'h01);
        apb(1'b1, 8'h1D, 8'h0A);
        rd_chk(8'h1D, 8'h00);
        loads(12'h003, 20'h00004, 20'h00005, 20'h00006, 20'h00007);
        sample_now();
        loads(12'h000, 20'h00000, 20'h00009, 20'h00000, 20'h00009);
        pulse(0, 0, 2, 0, 2);
        apb(1'b1, 8'h1D, 8'h05);
        sample_now();
        loads(12'h000, 20'h00000, 20'h00000, 20'h00000, 20'h00000);
        $display("clear test done");
    endtask : t_clear
    task t_overflow;
        pulse(4095, 0, 0, 0, 0);
        chk({31'h00000000, irq}, 32'h00000001);
        rd_chk(8'h20, 8'h01);
        rd_chk(8'h06, 8'h01);
        repeat (3) @(posedge pclk);
        chk({31'h00000000, irq}, 32'h00000000);
        pulse(2, 0, 0, 0, 0);
        sample_now();
        loads(12'h001, 20'h00000, 20'h00000, 20'h00000, 20'h00000);
        $display("overflow test done");
    endtask : t_overflow
    task t_unmapped;
        apb(1'b0, 8'h30, 8'h00);
        chk({31'h00000000, er}, 32'h00000001);
        apb(1'b1, 8'h30, 8'hFF);
        chk({31'h00000000, er}, 32'h00000001);
        rd_chk(8'h19, 8'h00);
        $display("unmapped test done");
    endtask : t_unmapped
    // reset for 20 cycles, then the scenarios in turn
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sample();
        t_pointer();
        t_clear();
        t_overflow();
        t_unmapped();
        results();
    end
endmodule : test_performance_counter_windows
